/* File: src/lbx_ctrl.sv */
// local bus expansion controller: mode register, decode and bus cycles
`timescale 1ns/1ps
`default_nettype none
module lbx_ctrl
  import lbx_pkg::*;
#(
  parameter logic [19:0] ROM_TOP_LOW  = 20'h3FFFF,
  parameter logic [19:0] ROM_TOP_HIGH = 20'h1FFFF,
  parameter logic [15:0] RAM_BASE     = 16'hD600
) (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST_N,
  input  wire logic                  I_REQ,
  input  wire lbx_req_type           I_REQ_BUS,
  input  wire logic                  I_LOC_HIGH,
  input  wire logic [ACC_WAIT_W-1:0] I_ACCESS_WAITS,
  input  wire logic [DATA_W-1:0]     I_MUX_ADDR_DATA,
  output logic                       O_ACK,
  output logic [DATA_W-1:0]          O_RDATA,
  output logic                       O_INTERNAL,
  output logic                       O_BUSY,
  output logic                       O_ADDR_LATCH_STROBE,
  output logic                       O_RD_N,
  output logic                       O_WR_N,
  output logic [DATA_W-1:0]          O_MUX_ADDR_DATA,
  output logic                       O_MUX_ADDR_DATA_OE,
  output logic [UP_W-1:0]            O_UPPER_ADDR_OUT,
  output logic [UP_W-1:0]            O_UPPER_ADDR_EN,
  output logic                       O_PORT_ALT_EN
);

  // elaboration check: data area base must lie below the external SFR window
  if (RAM_BASE >= EXT_SFR_LO) begin : g_bad_ram_base
    $error("RAM_BASE overlaps the external SFR window");
  end

  lbx_state_type              state_r;
  logic [7:0]                 expansion_mode_control_r;
  logic [DATA_W-1:0]          ad_sync1_r;
  logic [DATA_W-1:0]          ad_sync2_r;
  logic                       latch_strobe_r;
  logic                       rd_n_r;
  logic                       wr_n_r;
  logic [DATA_W-1:0]          ad_out_r;
  logic                       ad_oe_r;
  logic [UP_W-1:0]            up_r;
  logic [UP_W-1:0]            up_en_r;
  logic                       alt_en_r;
  logic                       ack_r;
  logic [DATA_W-1:0]          rdata_r;
  logic                       internal_r;
  logic                       busy_r;
  logic                       pins_r;
  logic                       we_r;
  logic [DATA_W-1:0]          wdata_r;
  logic                       addr_wait_pend_r;
  logic [ACC_WAIT_W-1:0]      wcnt_r;

  logic                       internal_fetch_speed_sel;
  logic                       addr_wait_en;
  logic [MODE_W-1:0]          exp_mode;
  logic [3:0]                 seg;
  logic [15:0]                low16;
  logic                       mode_hit;
  logic                       in_ext_sfr;
  logic                       in_data;
  logic                       in_rom;
  logic                       ext_on;
  logic [19:0]                amask;
  logic [19:0]                masked;
  logic [UP_W-1:0]            up_en;

  // mode register fields
  assign internal_fetch_speed_sel = expansion_mode_control_r[FETCH_BIT];
  assign addr_wait_en             = expansion_mode_control_r[AWAIT_BIT];
  assign exp_mode = expansion_mode_control_r[MODE_LSB +: MODE_W];

  // address decode of the internal areas for the current data area place
  assign seg        = I_LOC_HIGH ? SEG_HIGH : SEG_LOW;
  assign low16      = I_REQ_BUS.addr[15:0];
  assign mode_hit   = (I_REQ_BUS.addr == {seg, MODE_REG_OFS});
  assign in_ext_sfr = (I_REQ_BUS.addr[19:16] == seg) &&
                      (low16 >= EXT_SFR_LO) && (low16 <= EXT_SFR_HI);
  assign in_data    = (I_REQ_BUS.addr[19:16] == seg) &&
                      (low16 >= RAM_BASE) && (low16 <= DATA_AREA_TOP) &&
                      !in_ext_sfr;
  assign in_rom     = !in_data && !in_ext_sfr &&
                      (I_REQ_BUS.addr <=
                       (I_LOC_HIGH ? ROM_TOP_HIGH : ROM_TOP_LOW));

  // expansion size decode; unlisted codes act as single-chip
  always_comb begin
    ext_on = 1'b1;
    amask  = AMASK_NONE;
    case (exp_mode)
      MODE_256B: amask = AMASK_256B;
      MODE_1K:   amask = AMASK_1K;
      MODE_4K:   amask = AMASK_4K;
      MODE_16K:  amask = AMASK_16K;
      MODE_64K:  amask = AMASK_64K;
      MODE_256K: amask = AMASK_256K;
      MODE_1M:   amask = AMASK_1M;
      default:   ext_on = 1'b0;
    endcase
  end

  assign masked = I_REQ_BUS.addr & amask;
  assign up_en  = amask[19:8];

  // mode register: written by the core at its data_area_relocate_instr in the current data area segment
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      expansion_mode_control_r <= MODE_RESET;
    end else if (I_REQ && state_r == ST_IDLE && mode_hit &&
                 I_REQ_BUS.we) begin
      expansion_mode_control_r <= I_REQ_BUS.wdata & MODE_RD_MASK;
    end
  end

  // pin function selection follows the expansion mode
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      alt_en_r <= 1'b0;
      up_en_r  <= '0;
    end else begin
      alt_en_r <= ext_on;
      up_en_r  <= up_en;
    end
  end

  // two-stage synchroniser on the multiplexed bus input
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ad_sync1_r <= '0;
      ad_sync2_r <= '0;
    end else begin
      ad_sync1_r <= I_MUX_ADDR_DATA;
      ad_sync2_r <= ad_sync1_r;
    end
  end

  // bus cycle sequencer and pin drivers
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_r    <= ST_IDLE;
      latch_strobe_r <= 1'b0;
      rd_n_r     <= 1'b1;
      wr_n_r     <= 1'b1;
      ad_out_r   <= '0;
      ad_oe_r    <= 1'b0;
      up_r       <= '0;
      ack_r      <= 1'b0;
      rdata_r    <= '0;
      internal_r <= 1'b0;
      busy_r     <= 1'b0;
      pins_r     <= 1'b0;
      we_r       <= 1'b0;
      wdata_r    <= '0;
      addr_wait_pend_r <= 1'b0;
      wcnt_r     <= '0;
    end else begin
      ack_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (I_REQ) begin
            if (mode_hit) begin
              ack_r      <= 1'b1;
              internal_r <= 1'b1;
              rdata_r    <= expansion_mode_control_r & MODE_RD_MASK;
            end else if (in_data ||
                         (in_rom && internal_fetch_speed_sel)) begin
              ack_r      <= 1'b1;
              internal_r <= 1'b1;
              rdata_r    <= '0;
            end else if (!in_rom && !ext_on) begin
              ack_r      <= 1'b1; // no external space in single-chip
              internal_r <= 1'b0;
              rdata_r    <= '0;
            end else begin
              pins_r     <= !in_rom;
              internal_r <= in_rom;
              we_r       <= I_REQ_BUS.we;
              wdata_r    <= I_REQ_BUS.wdata;
              addr_wait_pend_r <= addr_wait_en;
              busy_r     <= 1'b1;
              state_r    <= ST_ADDR;
              if (!in_rom) begin
                latch_strobe_r <= 1'b1;
                ad_oe_r  <= 1'b1;
                ad_out_r <= masked[7:0];
                up_r     <= masked[19:8];
              end
            end
          end
        end
        ST_ADDR: begin
          if (addr_wait_pend_r) begin
            addr_wait_pend_r <= 1'b0;
          end else begin
            latch_strobe_r <= 1'b0;
            wcnt_r  <= I_ACCESS_WAITS;
            state_r <= ST_STRB;
            if (pins_r) begin
              rd_n_r   <= we_r;
              wr_n_r   <= !we_r;
              ad_oe_r  <= we_r;
              ad_out_r <= wdata_r;
            end
          end
        end
        ST_STRB: begin
          if (wcnt_r != '0) begin
            wcnt_r <= wcnt_r - 1'b1;
          end else begin
            rd_n_r  <= 1'b1;
            wr_n_r  <= 1'b1;
            ad_oe_r <= 1'b0;
            state_r <= ST_HOLD1;
          end
        end
        ST_HOLD1: begin
          state_r <= ST_HOLD2;
        end
        ST_HOLD2: begin
          rdata_r <= (pins_r && !we_r) ? ad_sync2_r : '0;
          ack_r   <= 1'b1;
          busy_r  <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign O_ACK               = ack_r;
  assign O_RDATA             = rdata_r;
  assign O_INTERNAL          = internal_r;
  assign O_BUSY              = busy_r;
  assign O_ADDR_LATCH_STROBE = latch_strobe_r;
  assign O_RD_N              = rd_n_r;
  assign O_WR_N              = wr_n_r;
  assign O_MUX_ADDR_DATA     = ad_out_r;
  assign O_MUX_ADDR_DATA_OE  = ad_oe_r;
  assign O_UPPER_ADDR_OUT    = up_r;
  assign O_UPPER_ADDR_EN     = up_en_r;
  assign O_PORT_ALT_EN       = alt_en_r;

endmodule
`default_nettype wire

/* File: src/lbx_pkg.sv */
// constants, field layout and types of the local bus expansion controller
// How it works
// - expansion turns strobe and port pins over automatically
// - only mode-sized upper address pins become outputs
// - read drives low address, floats, then samples data
// - address wait and access wait both supported
// - eight-bit mode register, reset value loaded
// - address-wait bit off disables, on enables waits
// - fetch bit chooses slow or fast internal ROM
// - external SFR window goes to external bus
// - mode field picks size; unlisted codes prohibited
// - address masked to size except in full mode
// - internal hits stay internal, pins hold, bus floats
package lbx_pkg;

  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 8;
  localparam int UP_W       = 12;
  localparam int MODE_W     = 4;
  localparam int ACC_WAIT_W = 2;

  // mode register data_area_relocate_instr, reset value and field layout
  localparam logic [15:0] MODE_REG_OFS  = 16'hFFC4;
  localparam logic [7:0]  MODE_RESET    = 8'h20;
  localparam logic [7:0]  MODE_RD_MASK  = 8'hAF;
  localparam int          FETCH_BIT     = 7;
  localparam int          AWAIT_BIT     = 5;
  localparam int          MODE_LSB      = 0;

  // data area data_area_relocate_instr, relocation nibble and external SFR window
  localparam logic [3:0]  SEG_LOW       = 4'h0;
  localparam logic [3:0]  SEG_HIGH      = 4'hF;
  localparam logic [15:0] DATA_AREA_TOP = 16'hFFFF;
  localparam logic [15:0] EXT_SFR_LO    = 16'hFFD0;
  localparam logic [15:0] EXT_SFR_HI    = 16'hFFDF;

  // expansion mode codes
  localparam logic [3:0] MODE_SINGLE = 4'h0;
  localparam logic [3:0] MODE_256B   = 4'h3;
  localparam logic [3:0] MODE_1K     = 4'h4;
  localparam logic [3:0] MODE_4K     = 4'h5;
  localparam logic [3:0] MODE_16K    = 4'h6;
  localparam logic [3:0] MODE_64K    = 4'h7;
  localparam logic [3:0] MODE_256K   = 4'h8;
  localparam logic [3:0] MODE_1M     = 4'h9;

  // address masks and upper pin enables per mode
  localparam logic [19:0] AMASK_256B = 20'h000FF;
  localparam logic [19:0] AMASK_1K   = 20'h003FF;
  localparam logic [19:0] AMASK_4K   = 20'h00FFF;
  localparam logic [19:0] AMASK_16K  = 20'h03FFF;
  localparam logic [19:0] AMASK_64K  = 20'h0FFFF;
  localparam logic [19:0] AMASK_256K = 20'h3FFFF;
  localparam logic [19:0] AMASK_1M   = 20'hFFFFF;
  localparam logic [19:0] AMASK_NONE = 20'h00000;

  // core request carried in one bundle
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lbx_req_type;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_STRB,
    ST_HOLD1,
    ST_HOLD2
  } lbx_state_type;

endpackage

/* File: tb/lbx_ctrl_properties.sv */
// port assertions of the local bus expansion controller
`timescale 1ns/1ps
`default_nettype none
module lbx_ctrl_properties
  import lbx_pkg::*;
(
  input wire logic            I_CLK,
  input wire logic            I_RST_N,
  input wire logic            O_ACK,
  input wire logic            O_BUSY,
  input wire logic            O_ADDR_LATCH_STROBE,
  input wire logic            O_RD_N,
  input wire logic            O_WR_N,
  input wire logic            O_MUX_ADDR_DATA_OE,
  input wire logic [UP_W-1:0] O_UPPER_ADDR_OUT,
  input wire logic [UP_W-1:0] O_UPPER_ADDR_EN,
  input wire logic            O_PORT_ALT_EN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // address phase, then a data strobe once the strobe drops
  sequence s_addr;
    O_ADDR_LATCH_STROBE && O_MUX_ADDR_DATA_OE && O_RD_N && O_WR_N;
  endsequence
  sequence s_data;
    !O_ADDR_LATCH_STROBE && !(O_RD_N && O_WR_N);
  endsequence
  a_addr_phase: assert property (
    $rose(O_ADDR_LATCH_STROBE) |-> s_addr ##[1:2] s_data)
    else $error("bad address phase");
  a_read_float: assert property (
    $fell(O_RD_N) |-> !O_MUX_ADDR_DATA_OE) else $error("bus not released");
  a_strobe_len: assert property (
    $fell(O_RD_N && O_WR_N) |-> ##[1:4] (O_RD_N && O_WR_N))
    else $error("strobe too long");
  a_ack_bound: assert property (
    $rose(O_ADDR_LATCH_STROBE) |-> ##[4:8] O_ACK) else $error("late ack");
  a_quiet_hold: assert property (
    $rose(O_BUSY) && !O_ADDR_LATCH_STROBE |-> $stable(O_UPPER_ADDR_OUT))
    else $error("pins moved");
  a_upper_steady: assert property (
    O_BUSY && $past(O_BUSY) |-> $stable(O_UPPER_ADDR_OUT))
    else $error("upper address moved");
  a_upper_masked: assert property (
    O_ADDR_LATCH_STROBE |-> (O_UPPER_ADDR_OUT & ~O_UPPER_ADDR_EN) == '0)
    else $error("address not masked");
  a_pins_contig: assert property (
    O_UPPER_ADDR_EN != '0 |-> O_PORT_ALT_EN &&
    (O_UPPER_ADDR_EN & (O_UPPER_ADDR_EN + 12'h001)) == '0)
    else $error("bad pin set");
endmodule
`default_nettype wire

/* File: tb/lbx_ext_mem.sv */
// behavioural external memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module lbx_ext_mem (
  input  wire logic       i_clk,
  input  wire logic       i_addr_strobe,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_oe,
  input  wire logic [7:0] i_ad,
  output logic      [7:0] o_ad
);
  logic [7:0] mem [256];
  logic [7:0] adr_r;
  logic [7:0] last_r = 8'h00;
  // low address byte kept while the strobe is high: the last value kept is
  // the one on the lines as the strobe falls, never the data that follows
  always_ff @(posedge i_clk) if (i_addr_strobe) adr_r <= i_ad;
  // byte stored while the write strobe is low
  always_ff @(posedge i_clk) if (!i_wr_n) mem[adr_r] <= i_ad;
  // wire level; an undriven bus toggles so stale data never matches
  assign o_ad = i_oe ? i_ad : (!i_rd_n ? mem[adr_r] : ~last_r);
  always @(posedge i_clk) last_r <= o_ad;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the local bus expansion controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lbx_pkg::*;
  logic            clk, rst_n, req, loc_high, ack, busy, intl;
  logic            addr_strobe, rd_n, wr_n, oe, alt;
  logic [1:0]      waits;
  logic [7:0]      ad_in, ad_out, rdata;
  logic [UP_W-1:0] up, up_en;
  lbx_req_type     rq;
  int              mismatches, checks, cyc, lat;
  lbx_ctrl lbx_ctrl_i (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ(req),
    .I_REQ_BUS(rq), .I_LOC_HIGH(loc_high), .I_ACCESS_WAITS(waits),
    .I_MUX_ADDR_DATA(ad_in), .O_ACK(ack), .O_RDATA(rdata),
    .O_INTERNAL(intl), .O_BUSY(busy), .O_ADDR_LATCH_STROBE(addr_strobe),
    .O_RD_N(rd_n), .O_WR_N(wr_n), .O_MUX_ADDR_DATA(ad_out),
    .O_MUX_ADDR_DATA_OE(oe), .O_UPPER_ADDR_OUT(up),
    .O_UPPER_ADDR_EN(up_en), .O_PORT_ALT_EN(alt));
  lbx_ext_mem lbx_ext_mem_i (.i_clk(clk), .i_addr_strobe(addr_strobe),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_oe(oe), .i_ad(ad_out), .o_ad(ad_in));
  // 40 MHz clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one request; lat counts cycles from the take edge to the ack
  task automatic acc(logic we, logic [19:0] a, logic [7:0] d);
    rq = '{we, a, d};
    req = 1;
    @(negedge clk);
    req = 0;
    lat = 1;
    while (ack !== 1'b1 && lat < 20) begin
      @(negedge clk);
      lat++;
    end
  endtask
  task automatic wmode(logic [7:0] v);
    acc(1, {loc_high ? SEG_HIGH : SEG_LOW, MODE_REG_OFS}, v);
    @(negedge clk);
  endtask
  task automatic t_mode_reg();
    acc(0, {SEG_LOW, MODE_REG_OFS}, 8'h00);
    chk("mode reset", rdata, 12'h020);
    chk("fast ack", 12'(lat), 12'h001);
    chk("single chip", alt, 12'h000);
    acc(0, 20'h54321, 8'h00);
    chk("no bus lat", 12'(lat), 12'h001);
    chk("no bus int", intl, 12'h000);
    chk("no bus rd", rdata, 12'h000);
    wmode(8'hFF);
    acc(0, {SEG_LOW, MODE_REG_OFS}, 8'h00);
    chk("mode fields", rdata, 12'h0AF);
    chk("prohibited", alt, 12'h000);
  endtask
  task automatic t_sizes();
    for (int c = 3; c < 10; c++) begin
      wmode(8'(c));
      chk("pins", up_en, 12'((1 << (2 * (c - 3))) - 1));
      chk("bus pins", alt, 12'h001);
    end
  endtask
  task automatic t_waits();
    wmode(8'h23);
    acc(1, 20'h54321, 8'h5A);
    chk("addr wait lat", 12'(lat), 12'h006);
    waits = 2'h2;
    acc(0, 20'h67821, 8'h00);
    chk("wait lat", 12'(lat), 12'h008);
    chk("masked rd", rdata, 12'h05A);
    chk("external", intl, 12'h000);
    wmode(8'h03);
    waits = 2'h0;
    acc(0, 20'h54321, 8'h00);
    chk("no addr wait lat", 12'(lat), 12'h005);
  endtask
  task automatic t_internal();
    acc(0, 20'h00100, 8'h00);
    chk("slow rom", 12'(lat), 12'h005);
    chk("internal", intl, 12'h001);
    wmode(8'h89);
    acc(0, 20'h54321, 8'h00);
    chk("full upper", up, 12'h543);
    chk("full rd", rdata, 12'h05A);
    acc(0, 20'h00100, 8'h00);
    chk("fast rom", 12'(lat), 12'h001);
    acc(1, 20'h0D700, 8'h11);
    chk("ram lat", 12'(lat), 12'h001);
    chk("pins held", up, 12'h543);
  endtask
  task automatic t_window();
    loc_high = 1;
    wmode(8'h09);
    acc(1, 20'hFFFD5, 8'h3C);
    chk("window wr", intl, 12'h000);
    acc(0, 20'hFFFD5, 8'h00);
    chk("window rd", rdata, 12'h03C);
    chk("full addr", up, 12'hFFF);
    acc(0, 20'hFFFC0, 8'h00);
    chk("sfr", intl, 12'h001);
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst_n = 0;
    req = 0;
    loc_high = 0;
    waits = 2'h0;
    rq = '0;
    repeat (16) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_mode_reg();
    t_sizes();
    t_waits();
    t_internal();
    t_window();
    end_sim();
  end
endmodule
bind lbx_ctrl lbx_ctrl_properties lbx_ctrl_properties_i (.I_CLK(I_CLK),
  .I_RST_N(I_RST_N), .O_ACK(O_ACK), .O_BUSY(O_BUSY),
  .O_ADDR_LATCH_STROBE(O_ADDR_LATCH_STROBE), .O_RD_N(O_RD_N),
  .O_WR_N(O_WR_N), .O_MUX_ADDR_DATA_OE(O_MUX_ADDR_DATA_OE),
  .O_UPPER_ADDR_OUT(O_UPPER_ADDR_OUT), .O_UPPER_ADDR_EN(O_UPPER_ADDR_EN),
  .O_PORT_ALT_EN(O_PORT_ALT_EN));
`default_nettype wire
